// ### include/opmode_pkg.sv
// Constants and carrier types for the operating-mode controller.
// Assumes one 200 MHz system clock and a seconds tick made by system logic.
package opmode_pkg;

  // Holding-register addresses, as Modbus register numbers.
  localparam logic [15:0] REG_MODE_COMMAND      = 16'h0014;
  localparam logic [15:0] REG_COMMAND_PASSWORD  = 16'h0065;
  localparam logic [15:0] REG_PROTECTED_COMMAND = 16'h0066;

  // Command values.
  localparam logic [15:0] CMD_OFF        = 16'h0001;
  localparam logic [15:0] CMD_MAN        = 16'h0002;
  localparam logic [15:0] CMD_AUTO       = 16'h0003;
  localparam logic [15:0] CMD_TEST       = 16'h0006;
  localparam logic [15:0] CMD_TEST_END   = 16'h0007;
  localparam logic [15:0] CMD_P_TEST     = 16'h000C;
  localparam logic [15:0] CMD_P_RSTART   = 16'h000D;
  localparam logic [15:0] CMD_RSTART     = 16'h0012;
  localparam logic [15:0] CMD_RSTART_END = 16'h0013;
  localparam logic [15:0] CMD_P_AUTO     = 16'h0015;

  // Setting bit positions.
  localparam int MBE_TEST_BIT   = 3;
  localparam int PANEL_COMBO_OFF_BIT = 1;
  localparam int LOG_MODE_BIT   = 0;

  // Timing.
  localparam longint unsigned CLK_HZ        = 64'd200_000_000;
  localparam longint unsigned PWD_WINDOW_S  = 64'd5;
  localparam longint unsigned COMM_LOSS_S   = 64'd60;
  localparam longint unsigned PWD_WINDOW_CYC = PWD_WINDOW_S * CLK_HZ;
  localparam longint unsigned COMM_LOSS_CYC  = COMM_LOSS_S * CLK_HZ;

  // Reset values.
  localparam logic [15:0] TIMER_RST = 16'h0000;
  localparam logic [33:0] CNT_RST   = 34'h0_0000_0000;

  typedef enum logic [2:0] {MODE_OFF, MODE_MAN, MODE_AUTO, MODE_TEST, MODE_RSTART} mode_t;
  typedef enum logic [2:0] {SRC_NONE, SRC_KEY, SRC_LEVEL, SRC_NOLOAD, SRC_LOAD, SRC_CAL, SRC_SERIAL} test_src_t;

  // Panel keys and digital inputs, all asynchronous pins.
  typedef struct packed {
    logic key_off;
    logic key_man;
    logic key_auto;
    logic key_start;
    logic key_ack;
    logic force_off;
    logic force_man;
    logic force_auto;
    logic test_level_input;
    logic test_noload_pulse_input;
    logic test_load_pulse_input;
    logic serial_cmd_enable_input;
    logic remote_start_enable_input;
    logic remote_start_input;
  } pins_t;

  // Settings, static during operation.
  typedef struct packed {
    logic [15:0] password;
    logic [15:0] test_duration;
    logic [15:0] rs_delay;
    logic [6:0]  test_days;
    logic [10:0] test_start_min;
    logic        supply_on_test;
    logic [7:0]  manual_brk_en;
    logic [7:0]  panel_opt;
    logic [7:0]  log_opt;
    logic        has_test_level;
    logic        has_serial_enable;
    logic        has_rs_enable;
  } cfg_t;

  // Plant state from the sequencing logic and calendar, same clock.
  typedef struct packed {
    logic        alarm_block;
    logic        auto_int_req;
    logic        power_load_inhibit;
    logic        mains_breaker_present;
    logic        close_permit;
    logic        sec_tick;
    logic [2:0]  weekday;
    logic [10:0] minute_of_day;
  } plant_t;

  typedef struct packed {
    logic ind_off;
    logic ind_man;
    logic ind_auto;
    logic ind_test;
    logic ind_rstart;
    logic out_not_off;
    logic out_automatic_group;
  } ind_t;

  typedef struct packed {
    logic engine_run;
    logic gen_close_auto;
    logic manual_brk_allowed;
    logic retransfer_mains;
    logic open_gen;
    logic normal_stop;
  } seq_t;

endpackage

// ### rtl/pin_sync.sv
// Two-flop synchroniser for all panel and digital-input pins.
// Assumes the pins are asynchronous to i_clk and change slowly.
module pin_sync (
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  // Pins
  input  wire opmode_pkg::pins_t i_pins,
  output opmode_pkg::pins_t      o_pins
);
  import opmode_pkg::*;

  pins_t meta;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta   <= '0;
      o_pins <= '0;
    end else begin
      meta   <= i_pins;
      o_pins <= meta;
    end
  end

endmodule

// ### rtl/operating_mode_controller.sv
// Operating-mode state machine: OFF/RESET, MAN, AUTO and the TEST and REMOTE START sub-modes.
// Assumes settings and plant state come from logic on i_clk; keys and inputs are raw pins.
// Behaviour
// RULE1: Password write, then command 1, 2 or 3 forces OFF, MAN or AUTO.
// RULE2: TEST runs engine; breaker closes with supply-on-test and permission, or always in a load-pulse test.
// RULE3: In TEST manual breaker commands allowed only with enable bit 3.
// RULE4: Leaving TEST retransfers loads to mains if present, then stops normally.
// RULE5: Intervention need ends TEST, loses request; active level input re-enters later.
// RULE6: TEST entry needs AUTO, no alarm, no remote start, no intervention.
// RULE7: Start plus ack keys toggle AUTO and TEST; nonzero duration ends test.
// RULE8: Level test input holds TEST while active, returns AUTO when released.
// RULE9: No-load pulse starts timed TEST, never closes breaker; second pulse ends.
// RULE10: Load pulse starts timed TEST, always closes breaker; second pulse ends.
// RULE11: Weekly calendar starts TEST at start time for the test interval.
// RULE12: Mode command 6 enters TEST, 7 returns to AUTO.
// RULE13: Password and command within 5 s; 12 TEST, 13 REMOTE START, 21 AUTO.
// RULE14: Protected commands need the serial enable input when configured.
// RULE15: Serial TEST cancelled after 60 s without any message.
// RULE16: REMOTE START runs engine, closes breaker unless inhibited, refuses manual.
// RULE17: Ending REMOTE START returns AUTO; without intervention opens breaker, stops.
// RULE18: REMOTE START only from AUTO or TEST, no alarm, enable input active.
// RULE19: Remote start input enters after its delay, leaves on release.
// RULE20: Mode command 18 enters REMOTE START, 19 returns to AUTO.
// RULE21: With log bit 0, each mode change records an event naming the mode.
// RULE22: Indication outputs per mode, not-off, and automatic group.
// RULE23: Forcing inputs prioritise OFF, MAN, AUTO and block selector and serial.
// RULE24: Exactly one mode held in an encoded clocked register.
module operating_mode_controller #(
  parameter logic [33:0] PWD_WINDOW_CYC = 34'(opmode_pkg::PWD_WINDOW_CYC),
  parameter logic [33:0] COMM_LOSS_CYC  = 34'(opmode_pkg::COMM_LOSS_CYC)
) (
  // Clock and reset
  input  wire logic               i_clk,
  input  wire logic               i_rst,
  // Holding-register writes and message activity
  input  wire logic               i_reg_wr,
  input  wire logic [15:0]        i_reg_addr,
  input  wire logic [15:0]        i_reg_wdata,
  input  wire logic               i_msg_rx,
  // Pins, settings and plant state
  input  wire opmode_pkg::pins_t  i_pins,
  input  wire opmode_pkg::cfg_t   i_cfg,
  input  wire opmode_pkg::plant_t i_plant,
  // Mode, indications, sequencing and event log
  output opmode_pkg::mode_t       o_mode,
  output opmode_pkg::ind_t        o_ind,
  output opmode_pkg::seq_t        o_seq,
  output logic                    o_evt_valid,
  output opmode_pkg::mode_t       o_evt_mode
);
  import opmode_pkg::*;

  pins_t       p;
  pins_t       p_prev;
  mode_t       mode, next_mode;
  mode_t       sel_main, next_sel;
  test_src_t   src, next_src;
  logic [15:0] timer, next_timer;
  logic        serial_rs, next_serial_rs;
  logic [15:0] rs_cnt, next_rs_cnt;
  logic        cal_prev, next_cal_prev;
  logic [33:0] pwd_cnt, next_pwd_cnt;
  logic        pwd_ok, next_pwd_ok;
  logic [33:0] comm_cnt, next_comm_cnt;
  ind_t        next_ind;
  seq_t        next_seq;
  logic        next_evt_valid;

  logic        forced, rs_in_ok, rs_allowed, rs_req, test_cond, comm_lost;
  logic        combo, combo_edge, noload_edge, load_edge, cal_match, cal_edge;
  logic        wr_cmd, wr_prot, prot_ok;
  mode_t       base;

  // Timed test sources load the duration and end on its expiry.
  function automatic logic timed(input test_src_t s);
    return (s == SRC_KEY) || (s == SRC_NOLOAD) || (s == SRC_LOAD) || (s == SRC_CAL);
  endfunction

  pin_sync u_sync (
    .i_clk  (i_clk),
    .i_rst  (i_rst),
    .i_pins (i_pins),
    .o_pins (p)
  );

  assign combo       = p.key_start && p.key_ack;
  assign combo_edge  = combo && !(p_prev.key_start && p_prev.key_ack)
                       && !i_cfg.panel_opt[PANEL_COMBO_OFF_BIT];                         // [RULE7]
  assign noload_edge = p.test_noload_pulse_input && !p_prev.test_noload_pulse_input;   // [RULE9]
  assign load_edge   = p.test_load_pulse_input && !p_prev.test_load_pulse_input;       // [RULE10]
  assign cal_match   = i_cfg.test_days[i_plant.weekday] && (i_plant.minute_of_day == i_cfg.test_start_min);
  assign cal_edge    = cal_match && !cal_prev;                                         // [RULE11]
  assign forced      = p.force_off || p.force_man || p.force_auto;
  assign wr_cmd      = i_reg_wr && (i_reg_addr == REG_MODE_COMMAND) && !forced;        // [RULE23]
  assign wr_prot     = i_reg_wr && (i_reg_addr == REG_PROTECTED_COMMAND);
  assign prot_ok     = wr_prot && pwd_ok && (pwd_cnt != CNT_RST) && !forced            // [RULE13]
                       && (!i_cfg.has_serial_enable || p.serial_cmd_enable_input);     // [RULE14]
  assign comm_lost   = (comm_cnt >= COMM_LOSS_CYC);                                    // [RULE15]
  assign rs_in_ok    = p.remote_start_input && (rs_cnt >= i_cfg.rs_delay);             // [RULE19]
  assign rs_allowed  = !i_plant.alarm_block
                       && (!i_cfg.has_rs_enable || p.remote_start_enable_input);       // [RULE18]
  assign test_cond   = !i_plant.alarm_block && !rs_req && !i_plant.auto_int_req;       // [RULE6]

  // Serial password window, message watchdog and remote-start input delay.
  always_comb begin
    next_pwd_cnt  = pwd_cnt;
    next_pwd_ok   = pwd_ok;
    next_comm_cnt = comm_cnt;
    next_rs_cnt   = rs_cnt;
    next_cal_prev = cal_match;
    if (i_reg_wr && (i_reg_addr == REG_COMMAND_PASSWORD)) begin
      next_pwd_ok  = (i_reg_wdata == i_cfg.password);                                  // [RULE1]
      next_pwd_cnt = PWD_WINDOW_CYC;                                                   // [RULE13]
    end else if (wr_prot) begin
      // One password admits one command; a second command needs a fresh password.
      next_pwd_ok  = 1'b0;
      next_pwd_cnt = CNT_RST;
    end else if (pwd_cnt != CNT_RST) begin
      next_pwd_cnt = pwd_cnt - 34'd1;
    end
    if (i_msg_rx || i_reg_wr) begin
      next_comm_cnt = CNT_RST;
    end else if (!comm_lost) begin
      next_comm_cnt = comm_cnt + 34'd1;
    end
    if (!p.remote_start_input) begin
      next_rs_cnt = TIMER_RST;                                                         // [RULE19]
    end else if (i_plant.sec_tick && (rs_cnt != 16'hFFFF)) begin
      next_rs_cnt = rs_cnt + 16'd1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pwd_cnt  <= CNT_RST;
      pwd_ok   <= 1'b0;
      comm_cnt <= CNT_RST;
      rs_cnt   <= TIMER_RST;
      cal_prev <= 1'b0;
      p_prev   <= '0;
    end else begin
      pwd_cnt  <= next_pwd_cnt;
      pwd_ok   <= next_pwd_ok;
      comm_cnt <= next_comm_cnt;
      rs_cnt   <= next_rs_cnt;
      cal_prev <= next_cal_prev;
      p_prev   <= p;
    end
  end

  // Mode selection and the AUTO sub-mode machine.
  always_comb begin
    next_mode      = mode;
    next_sel       = sel_main;
    next_src       = src;
    next_timer     = timer;
    next_serial_rs = serial_rs;
    base           = sel_main;
    rs_req         = 1'b0;
    if ((timer != TIMER_RST) && i_plant.sec_tick) begin
      next_timer = timer - 16'd1;
    end
    if (!forced) begin
      if (p.key_off && !p_prev.key_off) next_sel = MODE_OFF;
      else if (p.key_man && !p_prev.key_man) next_sel = MODE_MAN;
      else if (p.key_auto && !p_prev.key_auto) next_sel = MODE_AUTO;
      if (prot_ok && (i_reg_wdata == CMD_OFF)) next_sel = MODE_OFF;                    // [RULE1]
      if (prot_ok && (i_reg_wdata == CMD_MAN)) next_sel = MODE_MAN;                    // [RULE1]
      if (prot_ok && (i_reg_wdata == CMD_AUTO)) next_sel = MODE_AUTO;                  // [RULE1]
      base = next_sel;
    end else if (p.force_off) begin
      base = MODE_OFF;                                                                 // [RULE23]
    end else if (p.force_man) begin
      base = MODE_MAN;
    end else begin
      base = MODE_AUTO;
    end
    if (wr_cmd && (i_reg_wdata == CMD_RSTART)) next_serial_rs = 1'b1;                  // [RULE20]
    if (prot_ok && (i_reg_wdata == CMD_P_RSTART)) next_serial_rs = 1'b1;               // [RULE13]
    if ((wr_cmd && (i_reg_wdata == CMD_RSTART_END)) || (prot_ok && (i_reg_wdata == CMD_P_AUTO))) begin
      next_serial_rs = 1'b0;
    end
    rs_req = rs_in_ok || next_serial_rs;
    if (base != MODE_AUTO) begin
      next_mode      = base;
      next_src       = SRC_NONE;
      next_timer     = TIMER_RST;
      next_serial_rs = 1'b0;
    end else begin
      unique case (mode)
        MODE_OFF, MODE_MAN: begin
          next_mode = MODE_AUTO;
        end
        MODE_AUTO: begin
          if (test_cond) begin
            if ((wr_cmd && (i_reg_wdata == CMD_TEST)) || (prot_ok && (i_reg_wdata == CMD_P_TEST)))
              next_src = SRC_SERIAL;                                                   // [RULE12]
            else if (combo_edge) next_src = SRC_KEY;                                   // [RULE7]
            else if (noload_edge && (i_cfg.test_duration != TIMER_RST)) next_src = SRC_NOLOAD;
            else if (load_edge && (i_cfg.test_duration != TIMER_RST)) next_src = SRC_LOAD;
            else if (cal_edge && (i_cfg.test_duration != TIMER_RST)) next_src = SRC_CAL; // [RULE11]
            else if (i_cfg.has_test_level && p.test_level_input) next_src = SRC_LEVEL; // [RULE5] [RULE8]
            if (next_src != SRC_NONE) begin
              next_mode  = MODE_TEST;
              next_timer = timed(next_src) ? i_cfg.test_duration : TIMER_RST;
            end
          end
        end
        MODE_TEST: begin
          if (i_plant.auto_int_req                                                    // [RULE5]
              || (combo_edge && (src == SRC_KEY))                                      // [RULE7]
              || ((src == SRC_LEVEL) && !p.test_level_input)                           // [RULE8]
              || (noload_edge && (src == SRC_NOLOAD))                                  // [RULE9]
              || (load_edge && (src == SRC_LOAD))                                      // [RULE10]
              || (timed(src) && (timer == 16'd1) && i_plant.sec_tick)                  // [RULE7] [RULE11]
              || ((src == SRC_SERIAL) && comm_lost)                                    // [RULE15]
              || (wr_cmd && (i_reg_wdata == CMD_TEST_END))                             // [RULE12]
              || (prot_ok && (i_reg_wdata == CMD_P_AUTO))) begin                       // [RULE13]
            next_mode  = MODE_AUTO;
            next_src   = SRC_NONE;
            next_timer = TIMER_RST;
          end
        end
        MODE_RSTART: begin
          if (!rs_req) next_mode = MODE_AUTO;                                          // [RULE17] [RULE19]
        end
      endcase
      if ((mode == MODE_AUTO || mode == MODE_TEST) && rs_req && rs_allowed) begin    // [RULE18]
        next_mode  = MODE_RSTART;
        next_src   = SRC_NONE;
        next_timer = TIMER_RST;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mode      <= MODE_OFF;                                                           // [RULE24]
      sel_main  <= MODE_OFF;
      src       <= SRC_NONE;
      timer     <= TIMER_RST;
      serial_rs <= 1'b0;
    end else begin
      mode      <= next_mode;                                                          // [RULE24]
      sel_main  <= next_sel;
      src       <= next_src;
      timer     <= next_timer;
      serial_rs <= next_serial_rs;
    end
  end

  // Registered indications, sequencer requests and event record.
  always_comb begin
    next_ind                     = '0;
    next_ind.ind_off             = (next_mode == MODE_OFF);                            // [RULE22]
    next_ind.ind_man             = (next_mode == MODE_MAN);
    next_ind.ind_auto            = (next_mode == MODE_AUTO);
    next_ind.ind_test            = (next_mode == MODE_TEST);
    next_ind.ind_rstart          = (next_mode == MODE_RSTART);
    next_ind.out_not_off         = (next_mode != MODE_OFF);
    next_ind.out_automatic_group = (next_mode == MODE_AUTO) || (next_mode == MODE_TEST)
                                   || (next_mode == MODE_RSTART);
    next_seq            = '0;
    next_seq.engine_run = (next_mode == MODE_TEST) || (next_mode == MODE_RSTART);      // [RULE2] [RULE16]
    if (next_mode == MODE_TEST) begin
      // The breaker request is a wish; the sequencer still checks voltage and frequency.
      next_seq.gen_close_auto = (next_src == SRC_LOAD) ||                              // [RULE10]
                                ((next_src != SRC_NOLOAD) && i_cfg.supply_on_test && i_plant.close_permit); // [RULE2] [RULE9]
    end else if (next_mode == MODE_RSTART) begin
      next_seq.gen_close_auto = !i_plant.power_load_inhibit;                           // [RULE16]
    end
    next_seq.manual_brk_allowed = (next_mode == MODE_MAN) ||
                                  ((next_mode == MODE_TEST) && i_cfg.manual_brk_en[MBE_TEST_BIT]); // [RULE3]
    if ((mode == MODE_TEST) && (next_mode == MODE_AUTO)) begin
      next_seq.retransfer_mains = i_plant.mains_breaker_present;                      // [RULE4]
      next_seq.normal_stop      = 1'b1;
    end
    if ((mode == MODE_RSTART) && (next_mode == MODE_AUTO) && !i_plant.auto_int_req) begin
      next_seq.open_gen    = 1'b1;                                                     // [RULE17]
      next_seq.normal_stop = 1'b1;
    end
    next_evt_valid = (next_mode != mode) && i_cfg.log_opt[LOG_MODE_BIT];               // [RULE21]
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_ind       <= 7'b100_0000;
      o_seq       <= '0;
      o_evt_valid <= 1'b0;
      o_evt_mode  <= MODE_OFF;
    end else begin
      o_ind       <= next_ind;
      o_seq       <= next_seq;
      o_evt_valid <= next_evt_valid;
      o_evt_mode  <= next_mode;
    end
  end

  assign o_mode = mode;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // Only the first AUTO cycle after TEST carries the stop pulse, so the exit is anchored there.
  sequence test_exit_s;
    (mode == MODE_TEST) ##1 (mode == MODE_AUTO);
  endsequence

  one_mode_a: assert property ($onehot({o_ind.ind_off, o_ind.ind_man, o_ind.ind_auto, // [RULE24]
                                        o_ind.ind_test, o_ind.ind_rstart}))
    else $error("mode indication not one-hot");
  ind_group_a: assert property ((o_ind.out_not_off == !o_ind.ind_off) &&            // [RULE22]
                                (o_ind.out_automatic_group == (o_ind.ind_auto || o_ind.ind_test || o_ind.ind_rstart)))
    else $error("group indication wrong");
  test_entry_a: assert property ((mode != MODE_TEST) ##1 (mode == MODE_TEST) |-> $past(mode == MODE_AUTO, 1) // [RULE6]
                                 ##0 $past(!i_plant.auto_int_req && !i_plant.alarm_block, 1))
    else $error("illegal entry into TEST");
  test_leave_a: assert property ((mode == MODE_TEST) && i_plant.auto_int_req && !p.force_off && !p.force_man // [RULE5]
                                 |=> (mode == MODE_AUTO) || (mode == MODE_RSTART))
    else $error("TEST held during intervention");
  rs_entry_a: assert property ($rose(mode == MODE_RSTART) |-> $past(!i_plant.alarm_block)  // [RULE18]
                               && (($past(mode) == MODE_AUTO) || ($past(mode) == MODE_TEST)))
    else $error("illegal entry into REMOTE START");
  force_off_a: assert property (p.force_off |=> (mode == MODE_OFF))                 // [RULE23]
    else $error("forced OFF not obeyed");
  serial_test_a: assert property (wr_cmd && (i_reg_wdata == CMD_TEST) && (mode == MODE_AUTO) && test_cond // [RULE12]
                                  && (sel_main == MODE_AUTO) |=> (mode == MODE_TEST) && (src == SRC_SERIAL))
    else $error("command 6 did not enter TEST");
  pwd_window_a: assert property (wr_prot && (pwd_cnt == CNT_RST) && !p.key_off && !p.key_man && !p.key_auto // [RULE13]
                                 |=> (sel_main == $past(sel_main)))
    else $error("protected command accepted outside window");
  log_event_a: assert property (i_cfg.log_opt[LOG_MODE_BIT] && (next_mode != mode)    // [RULE21]
                                |=> o_evt_valid && (o_evt_mode == mode))
    else $error("mode change not logged");
  rs_manual_a: assert property ((mode == MODE_RSTART) |-> !o_seq.manual_brk_allowed && o_seq.engine_run) // [RULE16]
    else $error("manual breaker allowed in REMOTE START");
  noload_a: assert property ((mode == MODE_TEST) && (src == SRC_NOLOAD) |-> !o_seq.gen_close_auto) // [RULE9]
    else $error("no-load test closed breaker");
  test_stop_a: assert property (test_exit_s |-> o_seq.normal_stop // [RULE4]
                                && (o_seq.retransfer_mains == $past(i_plant.mains_breaker_present)))
    else $error("test end without normal stop");

endmodule

// ### bench/modbus_host_model.sv
// Host model: issues single-cycle holding-register writes.
// Assumes the controller samples writes on the rising edge of i_clk.
module modbus_host_model (
  // Clock
  input  wire logic   i_clk,
  // Write port
  output logic        o_wr,
  output logic [15:0] o_addr,
  output logic [15:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_wr   = 1'b0;
    o_addr = 16'h0000;
    o_data = 16'h0000;
  end
  // One word per write; password and command are separate writes.
  task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
    @(posedge i_clk);
    o_wr   <= 1'b1;
    o_addr <= a;
    o_data <= d;
    @(posedge i_clk);
    o_wr   <= 1'b0;
    // A stale word on an idle bus would hide decode faults.
    o_addr <= ~a;
    o_data <= ~d;
  endtask
endmodule

// ### bench/test_operating_mode_controller.sv
// Self-checking bench for the operating-mode controller.
// Assumes the host model and a seconds tick every four cycles.
module test_operating_mode_controller;
  import opmode_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk, i_rst, wr, evt;
  logic [15:0] addr, data;
  pins_t       pins;
  cfg_t        cfg;
  plant_t      plant;
  mode_t       mode, evt_mode;
  ind_t        ind;
  seq_t        seq;
  int          errors, samples_checked, evts, exp_evts, cyc, exp_mode;
  int          pc[3] = '{12, 13, 21};
  int          pe[4] = '{2, 3, 4, 2};
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    plant.sec_tick <= (cyc % 4 == 3);
  end
  always @(negedge i_clk) begin
    if (evt === 1'b1) evts++;
  end
  modbus_host_model i_modbus_host_model (.i_clk(i_clk), .o_wr(wr), .o_addr(addr), .o_data(data));
  operating_mode_controller #(.PWD_WINDOW_CYC(34'h0_0000_0014), .COMM_LOSS_CYC(34'h0_0000_0032))
    i_operating_mode_controller (.i_clk(i_clk), .i_rst(i_rst), .i_reg_wr(wr), .i_reg_addr(addr),
    .i_reg_wdata(data), .i_msg_rx(wr), .i_pins(pins), .i_cfg(cfg), .i_plant(plant), .o_mode(mode),
    .o_ind(ind), .o_seq(seq), .o_evt_valid(evt), .o_evt_mode(evt_mode));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("Checked %0d, mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Kinds: 0 register write (-1 means password), 1 pins, 2 alarm and intervention, 3 idle.
  task automatic step(input int k, input int a, input int b, input int e);
    int n;
    case (k)
      0: i_modbus_host_model.wr_reg(16'(a), (b < 0) ? cfg.password : 16'(b));
      1: begin @(posedge i_clk); pins <= pins_t'(a); end
      2: begin @(posedge i_clk); {plant.alarm_block, plant.auto_int_req} <= 2'(a); end
      default: repeat (a) @(posedge i_clk);
    endcase
    n = 0;
    while (mode !== mode_t'(e) && n < 40) begin @(negedge i_clk); n++; end
    repeat (4) @(negedge i_clk);
    if (e != exp_mode) exp_evts++;
    exp_mode = e;
    chk(32'(mode), 32'(e));
    chk(32'(evt_mode), 32'(e));
    chk(32'(ind), 32'({e == 0, e == 1, e == 2, e == 3, e == 4, e != 0, e >= 2}));
    $display("Step done, expected mode %0d", e);
    if (n == 40) begin
      errors++;
      wrap_up();
    end
  endtask
  initial begin
    void'($urandom(32'hbc233fe9));
    {errors, samples_checked, evts, exp_evts, cyc, exp_mode} = '0;
    i_rst = 1'b1;
    pins = pins_t'(14'h0006);
    cfg = '0;
    cfg.password = 16'($urandom());
    cfg.test_duration = 16'h0003;
    cfg.supply_on_test = 1'b1;
    cfg.manual_brk_en = 8'h08;
    cfg.test_days = 7'h01;
    cfg.test_start_min = 11'h005;
    cfg.rs_delay = 16'h0002;
    cfg.log_opt = 8'h01;
    {cfg.has_test_level, cfg.has_serial_enable, cfg.has_rs_enable} = 3'b111;
    plant = '0;
    plant.close_permit = 1'b1;
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    step(1, 0, 0, 0);
    step(0, 'h65, -1, 0);
    step(0, 'h66, 2, 0);
    step(1, 6, 0, 0);
    step(0, 'h65, -1, 0);
    step(0, 'h66, 2, 1);
    step(0, 'h65, -1, 1);
    step(0, 'h66, 3, 2);
    step(0, 'h65, -1, 2);
    step(3, 30, 0, 2);
    step(0, 'h66, 1, 2);
    step(0, 'h14, 6, 3);
    step(0, 'h14, 7, 2);
    step(0, 'h14, 18, 4);
    step(0, 'h14, 19, 2);
    for (int i = 0; i < 3; i++) begin
      step(0, 'h65, -1, pe[i]);
      step(0, 'h66, pc[i], pe[i + 1]);
    end
    step(0, 'h14, 6, 3);
    step(3, 70, 0, 2);
    step(1, 'h26, 0, 3);
    step(2, 1, 0, 2);
    step(2, 0, 0, 3);
    step(1, 6, 0, 2);
    step(2, 2, 0, 2);
    step(1, 'h26, 0, 2);
    step(1, 6, 0, 2);
    step(2, 0, 0, 2);
    step(1, 7, 0, 4);
    chk(32'({seq.engine_run, seq.gen_close_auto, seq.manual_brk_allowed}), 32'h0000_0006);
    step(1, 6, 0, 2);
    step(1, 5, 0, 2);
    step(3, 20, 0, 2);
    step(1, 6, 0, 2);
    step(1, 'h606, 0, 3);
    step(1, 6, 0, 2);
    step(1, 'h16, 0, 3);
    chk(32'(seq.gen_close_auto), 32'h0000_0000);
    chk(32'({seq.engine_run, seq.manual_brk_allowed}), 32'h0000_0003);
    step(1, 6, 0, 2);
    cfg.supply_on_test <= 1'b0;
    step(1, 'h0e, 0, 3);
    chk(32'(seq.gen_close_auto), 32'h0000_0001);
    step(1, 6, 0, 2);
    @(posedge i_clk);
    plant.minute_of_day <= cfg.test_start_min;
    step(3, 1, 0, 3);
    step(3, 1, 0, 2);
    step(1, 'h106, 0, 0);
    step(0, 'h65, -1, 0);
    step(0, 'h66, 3, 0);
    chk(32'(evts), 32'(exp_evts));
    wrap_up();
  end
endmodule
